// ### ddr_link_pkg.sv
// Shared constants, field layouts and helper functions for the memory link
package ddr_link_pkg;
	// Clock and timing
	localparam int CLK_PERIOD_NS     = 40;
	localparam int CRC_ALERT_NS      = 240;
	localparam int PAR_RECOVER_NS    = 400;
	localparam int CRC_ALERT_CYCLES  =
		(CRC_ALERT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PAR_RECOVER_CYCLES =
		(PAR_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Link widths and burst shape
	localparam int DQ_W      = 8;
	localparam int ADDR_W    = 14;
	localparam int CA_W      = 22;
	localparam int MEM_DEPTH = 32;
	localparam int IDX_W     = 5;
	localparam logic [2:0] BURST_LEN  = 3'h4;
	localparam logic [2:0] BURST_LAST = 3'h3;
	localparam logic [7:0] CRC_POLY   = 8'h07;
	localparam logic [3:0] ALERT_CRC  = 4'(CRC_ALERT_CYCLES);
	localparam logic [3:0] ALERT_PAR  = 4'(PAR_RECOVER_CYCLES);
	// Command codes on the dual-use pins with the activate line high
	localparam logic [2:0] CMD_READ  = 3'h5;
	localparam logic [2:0] CMD_WRITE = 3'h4;
	// Mask/inversion pin selection bits
	localparam int MR5_DM   = 0;
	localparam int MR5_WDBI = 1;
	localparam int MR5_RDBI = 2;
	// Controller register map (word index)
	localparam logic [2:0] REG_CTRL   = 3'h0;
	localparam logic [2:0] REG_CMD    = 3'h1;
	localparam logic [2:0] REG_WDATA  = 3'h2;
	localparam logic [2:0] REG_RDATA  = 3'h3;
	localparam logic [2:0] REG_STATUS = 3'h4;
	localparam logic [2:0] REG_MASK   = 3'h5;
	// Control register fields
	localparam int CTL_CRC    = 0;
	localparam int CTL_WDBI   = 1;
	localparam int CTL_DM     = 2;
	localparam int CTL_RDBI   = 3;
	localparam int CTL_TERM   = 4;
	localparam int CTL_INJECT = 5;
	localparam int CTL_LRST   = 6;
	localparam int CTL_WMASK  = 8;
	localparam logic [11:0] CTRL_RESET = 12'h000;
	// Command register fields
	localparam int CMDF_OP   = 0;
	localparam int CMDF_ADDR = 4;
	localparam int CMDF_BANK = 18;
	localparam int CMDF_ROW  = 22;
	localparam logic [1:0] OP_READ  = 2'h0;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_ACT   = 2'h2;
	// Status bits
	localparam int ST_DONE  = 0;
	localparam int ST_CRC   = 1;
	localparam int ST_ALERT = 2;
	localparam int ST_EVENT = 3;
	localparam int ST_BUSY  = 4;

	// One byte step of the burst checksum
	function automatic logic [7:0] crc8_step(input logic [7:0] crc_in,
		input logic [7:0] data);
		logic [7:0] c;
		c = crc_in ^ data;
		for (int i = 0; i < 8; i++)
			c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
		return c;
	endfunction : crc8_step

	// True when a byte has more than half its bits set
	function automatic logic dbi_needed(input logic [7:0] d);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < 8; i++)
			n = n + {3'h0, d[i]};
		return n > 4'h4;
	endfunction : dbi_needed

	// Even parity over the command/address group
	function automatic logic ca_parity(input logic [CA_W-1:0] v);
		return ^v;
	endfunction : ca_parity
endpackage : ddr_link_pkg

// ### ddr_link_if.sv
// Pin-level link between the memory controller and the DRAM end
`timescale 1ns/1ns
interface ddr_link_if;
	import ddr_link_pkg::*;
	// Controller-driven pins
	logic              reset_link_n;
	logic              cs_n;
	logic              activate_strobe_n;
	logic              row_strobe_or_addr16;
	logic              col_strobe_or_addr15;
	logic              write_strobe_or_addr14;
	logic [1:0]        bg;
	logic [1:0]        ba;
	logic [ADDR_W-1:0] addr;
	logic              parity;
	logic              termination_enable_in;
	// Two-way pin halves, controller side
	logic [DQ_W-1:0]   h_dq;
	logic              h_dq_oe_n;
	logic              h_strobe;
	logic              h_strobe_oe_n;
	logic              h_mask_n;
	logic              h_mask_oe_n;
	// Two-way pin halves, DRAM side
	logic [DQ_W-1:0]   d_dq;
	logic              d_dq_oe_n;
	logic              d_strobe;
	logic              d_strobe_oe_n;
	logic              d_mask_n;
	logic              d_mask_oe_n;
	logic              d_alert;
	logic              d_alert_oe_n;
	logic              event_n;
	// Resolved wire levels
	logic [DQ_W-1:0]   dq;
	logic              lower_byte_strobe;
	logic              mask_invert_n;
	logic              alert_n;

	// Bus resolution; undriven data and mask float high, strobe low
	assign dq = !h_dq_oe_n ? h_dq : (!d_dq_oe_n ? d_dq : 8'hFF);
	assign lower_byte_strobe = !h_strobe_oe_n ? h_strobe :
		(!d_strobe_oe_n ? d_strobe : 1'b0);
	assign mask_invert_n = !h_mask_oe_n ? h_mask_n :
		(!d_mask_oe_n ? d_mask_n : 1'b1);
	assign alert_n = d_alert_oe_n | d_alert;

	modport ctrl (
		output reset_link_n, cs_n, activate_strobe_n, row_strobe_or_addr16,
		output col_strobe_or_addr15, write_strobe_or_addr14, bg, ba, addr,
		output parity, termination_enable_in, h_dq, h_dq_oe_n, h_strobe,
		output h_strobe_oe_n, h_mask_n, h_mask_oe_n,
		input  dq, lower_byte_strobe, mask_invert_n, alert_n, event_n
	);
	modport dram (
		input  reset_link_n, cs_n, activate_strobe_n, row_strobe_or_addr16,
		input  col_strobe_or_addr15, write_strobe_or_addr14, bg, ba, addr,
		input  parity, termination_enable_in,
		input  dq, lower_byte_strobe, mask_invert_n,
		output d_dq, d_dq_oe_n, d_strobe, d_strobe_oe_n, d_mask_n,
		output d_mask_oe_n, d_alert, d_alert_oe_n, event_n
	);
endinterface : ddr_link_if

// ### ddr_dram_end.sv
// DRAM end of the memory link: command decode, data bursts, alert, event
// Behaviour
// - Termination input high applies termination to data group
// - Termination input ignored when termination disabled
// - Parity checked over activate, command, bank, address
// - Controller sends parity with command, chip select low
// - Activate low: dual pins are row bits
// - Low reset input resets asynchronously; controller holds high
// - Checksum beat follows data beats when enabled
// - Reference monitor mode flagged on low data lines; the code leaves the data lines alone and raises vref_monitor_active instead
// - Write beat discarded when mask sampled low
// - Mode bits choose mask, inversion or termination strobe
// - Inversion low means data is inverted
// - Read strobe edge-aligned, write strobe centre-aligned; the controller drives the write strobe edge-aligned with its data
// - One strobe pair times data lines 7:0
// - Write checksum error pulses alert low
// - Parity error holds alert low through recovery
// - Connectivity test mode makes alert an input
// - Critical temperature drives event output low
// - Commands ignored while chip select high
//
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/1ns
module ddr_dram_end
	import ddr_link_pkg::*;
(
	// Clock
	input  wire logic       core_clk,
	// Link
	ddr_link_if.dram        link,
	// Mode settings
	input  wire logic       rtt_enable,
	input  wire logic       parity_enable,
	input  wire logic       crc_enable,
	input  wire logic [2:0] mode_reg_five,
	input  wire logic       mode_reg_one_a11,
	input  wire logic       mode_reg_four_a4,
	input  wire logic       conn_test,
	input  wire logic       temp_critical,
	// Status
	output logic            termination_active,
	output logic            vref_monitor_active
);
	typedef enum logic [1:0] {S_IDLE, S_WRITE, S_READ, S_RECOVER} dev_state_t;

	dev_state_t       state;
	dev_state_t       next_state;
	logic [2:0]       beat;
	logic [2:0]       next_beat;
	logic [7:0]       mem [MEM_DEPTH];
	logic             open_row;
	logic [1:0]       col_base;
	logic [7:0]       crc;
	logic [3:0]       alert_cnt;
	logic [3:0]       next_alert_cnt;
	logic             prev_strobe;

	// Command decode; chip select high masks everything
	wire              cmd_sel = ~link.cs_n;
	wire [CA_W-1:0]   ca_vec = {link.activate_strobe_n,
		link.row_strobe_or_addr16, link.col_strobe_or_addr15,
		link.write_strobe_or_addr14, link.bg, link.ba, link.addr};
	wire              par_bad = parity_enable & cmd_sel &
		(ca_parity(ca_vec) ^ link.parity);
	wire              is_cmd = cmd_sel & ~par_bad & (state == S_IDLE);
	wire [2:0]        cmd_code = {link.row_strobe_or_addr16,
		link.col_strobe_or_addr15, link.write_strobe_or_addr14};
	wire              is_act = is_cmd & ~link.activate_strobe_n;
	wire              is_rd = is_cmd & link.activate_strobe_n &
		(cmd_code == CMD_READ);
	wire              is_wr = is_cmd & link.activate_strobe_n &
		(cmd_code == CMD_WRITE);

	// Shared pin function selection
	wire              termination_strobe_on = mode_reg_one_a11;
	wire              dm_on = mode_reg_five[MR5_DM] & ~termination_strobe_on;
	wire              wdbi_on = mode_reg_five[MR5_WDBI] & ~termination_strobe_on &
		~dm_on;
	wire              rdbi_on = mode_reg_five[MR5_RDBI] & ~termination_strobe_on;

	// Write beats are taken on either strobe edge
	wire              tog = link.lower_byte_strobe ^ prev_strobe;
	wire              wr_take = (state == S_WRITE) & tog;
	wire              data_beat = beat < BURST_LEN;
	wire              wr_keep = ~(dm_on & ~link.mask_invert_n);
	wire [7:0]        wr_byte = (wdbi_on & ~link.mask_invert_n) ?
		~link.dq : link.dq;
	wire [IDX_W-1:0]  idx = {open_row, col_base, beat[1:0]};
	wire              last_beat = crc_enable ? (beat == BURST_LEN) :
		(beat == BURST_LAST);
	wire              crc_fail = wr_take & crc_enable &
		(beat == BURST_LEN) & (link.dq != crc);

	// Read beat selection
	wire [7:0]        rd_raw = mem[idx];
	wire              rd_inv = rdbi_on & dbi_needed(rd_raw);
	wire [7:0]        rd_byte = rd_inv ? ~rd_raw : rd_raw;
	wire              rd_live = state == S_READ;

	// Next state and beat
	always_comb
	begin
		next_state = state;
		next_beat = beat;
		if (par_bad)
			next_state = S_RECOVER;
		else
		begin
			unique case (state)
				S_IDLE:
				begin
					next_beat = 3'h0;
					if (is_rd)
						next_state = S_READ;
					else if (is_wr)
						next_state = S_WRITE;
				end
				S_WRITE:
					if (tog)
					begin
						next_beat = beat + 3'h1;
						if (last_beat)
							next_state = S_IDLE;
					end
				S_READ:
				begin
					next_beat = beat + 3'h1;
					if (last_beat)
						next_state = S_IDLE;
				end
				S_RECOVER:
					if (alert_cnt == 4'h1)
						next_state = S_IDLE;
			endcase
		end
	end

	// Alert counter: parity holds through recovery, checksum is a pulse
	always_comb
	begin
		next_alert_cnt = alert_cnt;
		if (par_bad)
			next_alert_cnt = ALERT_PAR;
		else if (crc_fail)
			next_alert_cnt = ALERT_CRC;
		else if (alert_cnt != 4'h0)
			next_alert_cnt = alert_cnt - 4'h1;
	end

	// Sequencer registers, reset by the link reset pin
	always_ff @(posedge core_clk or negedge link.reset_link_n)
	begin
		if (!link.reset_link_n)
		begin
			state <= S_IDLE;
			beat <= 3'h0;
			alert_cnt <= 4'h0;
			prev_strobe <= 1'b0;
		end
		else
		begin
			state <= next_state;
			beat <= next_beat;
			alert_cnt <= next_alert_cnt;
			prev_strobe <= link.lower_byte_strobe;
		end
	end

	// Row and column latches
	always_ff @(posedge core_clk or negedge link.reset_link_n)
	begin
		if (!link.reset_link_n)
		begin
			open_row <= 1'b0;
			col_base <= 2'h0;
		end
		else
		begin
			if (is_act)
				open_row <= link.addr[0];
			if (is_rd | is_wr)
				col_base <= link.addr[3:2];
		end
	end

	// Burst checksum, over the bytes as they cross the wire
	always_ff @(posedge core_clk or negedge link.reset_link_n)
	begin
		if (!link.reset_link_n)
			crc <= 8'h00;
		else if (state == S_IDLE)
			crc <= 8'h00;
		else if (wr_take & data_beat)
			crc <= crc8_step(crc, link.dq);
		else if (rd_live & data_beat)
			crc <= crc8_step(crc, rd_byte);
	end

	// Storage array, written only with unmasked beats
	always_ff @(posedge core_clk)
	begin
		if (wr_take & data_beat & wr_keep)
			mem[idx] <= wr_byte;
	end

	// Read drive: strobe toggles with each beat, edge-aligned
	always_ff @(posedge core_clk or negedge link.reset_link_n)
	begin
		if (!link.reset_link_n)
		begin
			link.d_dq <= 8'h00;
			link.d_dq_oe_n <= 1'b1;
			link.d_strobe <= 1'b0;
			link.d_strobe_oe_n <= 1'b1;
			link.d_mask_n <= 1'b1;
			link.d_mask_oe_n <= 1'b1;
		end
		else
		begin
			link.d_dq <= data_beat ? rd_byte : crc;
			link.d_dq_oe_n <= ~rd_live;
			link.d_strobe <= rd_live & ~link.d_strobe;
			link.d_strobe_oe_n <= ~rd_live;
			link.d_mask_n <= ~(rd_inv & data_beat);
			link.d_mask_oe_n <= ~(rd_live & rdbi_on);
		end
	end

	// Alert, event and mode status pins
	always_ff @(posedge core_clk or negedge link.reset_link_n)
	begin
		if (!link.reset_link_n)
		begin
			link.d_alert <= 1'b0;
			link.d_alert_oe_n <= 1'b1;
			link.event_n <= 1'b1;
			termination_active <= 1'b0;
			vref_monitor_active <= 1'b0;
		end
		else
		begin
			link.d_alert <= 1'b0;
			link.d_alert_oe_n <= conn_test |
				(next_alert_cnt == 4'h0);
			link.event_n <= ~temp_critical;
			termination_active <= link.termination_enable_in &
				rtt_enable;
			vref_monitor_active <= mode_reg_four_a4;
		end
	end
endmodule : ddr_dram_end

// ### ddr_ctrl_end.sv
// Controller end of the memory link with its software register port
`timescale 1ns/1ns
module ddr_ctrl_end
	import ddr_link_pkg::*;
(
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	// Register port
	input  wire logic [2:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	output logic             irq,
	// Link
	ddr_link_if.ctrl         link
);
	typedef enum logic [1:0] {H_IDLE, H_CMD, H_WRITE, H_READ} host_state_t;

	host_state_t  state;
	host_state_t  next_state;
	logic [11:0]  ctrl;
	logic [31:0]  cmd;
	logic [31:0]  wdata;
	logic [31:0]  rdata;
	logic [3:0]   status;
	logic [3:0]   mask;
	logic [2:0]   beat;
	logic [7:0]   crc;
	logic         prev_strobe;

	// Register decode
	wire          wr_ctrl = reg_wr & (reg_addr == REG_CTRL);
	wire          wr_cmd = reg_wr & (reg_addr == REG_CMD);
	wire          wr_stat = reg_wr & (reg_addr == REG_STATUS);
	wire          busy = state != H_IDLE;
	wire          go = wr_cmd & ~busy;
	wire [1:0]    op = cmd[CMDF_OP +: 2];
	wire          crc_on = ctrl[CTL_CRC];
	wire          data_beat = beat < BURST_LEN;
	wire          last_beat = crc_on ? (beat == BURST_LEN) :
		(beat == BURST_LAST);

	// Command pins built from the order just written
	wire [1:0]    new_op = reg_wdata[CMDF_OP +: 2];
	wire          new_act = new_op != OP_ACT;
	wire [2:0]    new_code = (new_op == OP_ACT) ? reg_wdata[CMDF_ROW +: 3] :
		((new_op == OP_WRITE) ? CMD_WRITE : CMD_READ);
	wire [CA_W-1:0] new_ca = {new_act, new_code,
		reg_wdata[CMDF_BANK +: 4], reg_wdata[CMDF_ADDR +: ADDR_W]};

	// Write beat, with optional inversion and masking
	wire [7:0]    wr_raw = wdata[{beat[1:0], 3'h0} +: 8];
	wire          wr_inv = ctrl[CTL_WDBI] & dbi_needed(wr_raw);
	wire [7:0]    wr_byte = wr_inv ? ~wr_raw : wr_raw;
	wire          wr_masked = ctrl[CTL_DM] &
		ctrl[CTL_WMASK + {30'h0, beat[1:0]}];
	wire          drv = state == H_WRITE;

	// Read beat capture on either edge of the returned strobe
	wire          tog = link.lower_byte_strobe ^ prev_strobe;
	wire          rd_take = (state == H_READ) & tog;
	wire [7:0]    rd_byte = (ctrl[CTL_RDBI] & ~link.mask_invert_n) ?
		~link.dq : link.dq;
	wire          crc_bad = rd_take & crc_on & (beat == BURST_LEN) &
		(link.dq != crc);
	wire          finished = (drv & last_beat) | (rd_take & last_beat) |
		((state == H_CMD) & (op == OP_ACT)) |
		((state == H_READ) & ~link.alert_n);

	// Status events, set winning over a write-one clear
	wire [3:0]    st_set = {~link.event_n, ~link.alert_n, crc_bad, finished};
	wire [3:0]    next_status = (status & ~(wr_stat ? reg_wdata[3:0] : 4'h0))
		| st_set;

	// Sequencer next state
	always_comb
	begin
		next_state = state;
		unique case (state)
			H_IDLE:
				if (go)
					next_state = H_CMD;
			H_CMD:
				next_state = (op == OP_WRITE) ? H_WRITE :
					((op == OP_READ) ? H_READ : H_IDLE);
			H_WRITE, H_READ:
				if (finished)
					next_state = H_IDLE;
		endcase
	end

	// Software registers and sequencer
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= H_IDLE;
			ctrl <= CTRL_RESET;
			cmd <= 32'h0000_0000;
			wdata <= 32'h0000_0000;
			mask <= 4'h0;
			status <= 4'h0;
			irq <= 1'b0;
		end
		else
		begin
			state <= next_state;
			if (wr_ctrl)
				ctrl <= reg_wdata[11:0];
			if (go)
				cmd <= reg_wdata;
			if (reg_wr & (reg_addr == REG_WDATA))
				wdata <= reg_wdata;
			if (reg_wr & (reg_addr == REG_MASK))
				mask <= reg_wdata[3:0];
			status <= next_status;
			irq <= |(next_status & mask);
		end
	end

	// Beat counter, checksum and read capture
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			beat <= 3'h0;
			crc <= 8'h00;
			rdata <= 32'h0000_0000;
			prev_strobe <= 1'b0;
		end
		else
		begin
			prev_strobe <= link.lower_byte_strobe;
			if (~(drv | rd_take) & (state != H_READ))
			begin
				beat <= 3'h0;
				crc <= 8'h00;
			end
			else if (drv | rd_take)
			begin
				beat <= beat + 3'h1;
				if (data_beat)
					crc <= crc8_step(crc, drv ? wr_byte : link.dq);
				if (rd_take & data_beat)
					rdata[{beat[1:0], 3'h0} +: 8] <= rd_byte;
			end
		end
	end

	// Register read data, one cycle after the strobe
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			reg_rdata <= 32'h0000_0000;
		else if (reg_rd)
			unique case (reg_addr)
				REG_CTRL:   reg_rdata <= {20'h0, ctrl};
				REG_CMD:    reg_rdata <= cmd;
				REG_WDATA:  reg_rdata <= wdata;
				REG_RDATA:  reg_rdata <= rdata;
				REG_STATUS: reg_rdata <= {27'h0, busy, status};
				REG_MASK:   reg_rdata <= {28'h0, mask};
				default:    reg_rdata <= 32'h0000_0000;
			endcase
	end

	// Command pins: parity travels with the command, chip select low
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			link.reset_link_n <= 1'b0;
			link.cs_n <= 1'b1;
			link.activate_strobe_n <= 1'b1;
			link.row_strobe_or_addr16 <= 1'b1;
			link.col_strobe_or_addr15 <= 1'b1;
			link.write_strobe_or_addr14 <= 1'b1;
			link.bg <= 2'h0;
			link.ba <= 2'h0;
			link.addr <= 14'h0000;
			link.parity <= 1'b0;
			link.termination_enable_in <= 1'b0;
		end
		else
		begin
			link.reset_link_n <= ~ctrl[CTL_LRST];
			link.cs_n <= ~go;
			link.termination_enable_in <= ctrl[CTL_TERM];
			if (go)
			begin
				link.activate_strobe_n <= new_act;
				{link.row_strobe_or_addr16, link.col_strobe_or_addr15,
					link.write_strobe_or_addr14} <= new_code;
				{link.bg, link.ba} <= reg_wdata[CMDF_BANK +: 4];
				link.addr <= reg_wdata[CMDF_ADDR +: ADDR_W];
				link.parity <= ca_parity(new_ca) ^ ctrl[CTL_INJECT];
			end
		end
	end

	// Write data drive: strobe toggles with each beat
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			link.h_dq <= 8'h00;
			link.h_dq_oe_n <= 1'b1;
			link.h_strobe <= 1'b0;
			link.h_strobe_oe_n <= 1'b1;
			link.h_mask_n <= 1'b1;
			link.h_mask_oe_n <= 1'b1;
		end
		else
		begin
			link.h_dq <= data_beat ? wr_byte : crc;
			link.h_dq_oe_n <= ~drv;
			link.h_strobe <= drv & ~link.h_strobe;
			link.h_strobe_oe_n <= ~drv;
			link.h_mask_n <= ~(data_beat & (wr_inv | wr_masked));
			link.h_mask_oe_n <= ~(drv & (ctrl[CTL_WDBI] | ctrl[CTL_DM]));
		end
	end
endmodule : ddr_ctrl_end

// ### ddr_link_checker.sv
// Assertions on the pins between the controller and DRAM ends
`timescale 1ns/1ns
module ddr_link_checker
	import ddr_link_pkg::*;
(
	// Clock and controller reset
	input wire logic        core_clk,
	input wire logic        rst_n,
	// Command pins
	input wire logic        reset_link_n,
	input wire logic        cs_n,
	input wire logic        activate_strobe_n,
	input wire logic        row_strobe_or_addr16,
	input wire logic        col_strobe_or_addr15,
	input wire logic        write_strobe_or_addr14,
	input wire logic [1:0]  bg,
	input wire logic [1:0]  ba,
	input wire logic [13:0] addr,
	input wire logic        parity,
	input wire logic        termination_enable_in,
	// Data group and flags
	input wire logic        h_dq_oe_n,
	input wire logic        d_dq_oe_n,
	input wire logic        d_strobe_oe_n,
	input wire logic        d_mask_oe_n,
	input wire logic        lower_byte_strobe,
	input wire logic        alert_n,
	input wire logic        event_n,
	// Device mode and status
	input wire logic        rtt_enable,
	input wire logic        parity_enable,
	input wire logic        temp_critical,
	input wire logic        termination_active
);
	logic [2:0] code;
	logic       cmd;
	logic       rd_cmd;
	logic       par_bad;
	logic       term_req;

	// Command decode as seen on the pins
	assign code = {row_strobe_or_addr16, col_strobe_or_addr15,
		write_strobe_or_addr14};
	assign cmd = !cs_n && reset_link_n;
	assign rd_cmd = cmd && activate_strobe_n && code == CMD_READ;
	assign par_bad = parity != ^{activate_strobe_n, code, bg, ba, addr};
	assign term_req = termination_enable_in && rtt_enable;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	AST_PAR_ALERT: assert property (
		cmd && parity_enable && par_bad |=>
		(!alert_n)[*8] ##1 (!alert_n)[*2] ##1 alert_n)
		else $error("alert not low for the parity recovery time");
	AST_CRC_ALERT: assert property (
		$fell(alert_n) |-> (!alert_n)[*6])
		else $error("alert pulse shorter than six cycles");
	AST_READ_LAUNCH: assert property (
		$fell(d_dq_oe_n) |-> $past(rd_cmd, 2))
		else $error("read data driven without a selected read");
	AST_NO_CLASH: assert property (
		!(!h_dq_oe_n && !d_dq_oe_n))
		else $error("both ends drive the data lines");
	AST_READ_STROBE: assert property (
		!d_dq_oe_n |-> !d_strobe_oe_n)
		else $error("read data without a driven strobe");
	AST_BEAT_TOGGLE: assert property (
		(!d_dq_oe_n || !h_dq_oe_n) && $past(!d_dq_oe_n || !h_dq_oe_n)
		|-> lower_byte_strobe != $past(lower_byte_strobe))
		else $error("strobe did not toggle on a data beat");
	AST_TERM: assert property (
		reset_link_n && $past(reset_link_n) |->
		termination_active == $past(term_req))
		else $error("termination state does not follow its request");
	AST_EVENT_ON: assert property (
		(reset_link_n && temp_critical)[*2] |-> !event_n)
		else $error("event output not low at critical temperature");
	AST_EVENT_OFF: assert property (
		(reset_link_n && !temp_critical)[*2] |-> event_n)
		else $error("event output low without critical temperature");
	AST_LINK_RST: assert property (
		!reset_link_n |-> d_dq_oe_n && d_strobe_oe_n && d_mask_oe_n)
		else $error("device drives pins during link reset");
endmodule : ddr_link_checker

// ### ddr4_module_pin_interface_behaviour_tb.sv
// Self-checking bench joining the controller and DRAM ends
`timescale 1ns/1ns
module ddr4_module_pin_interface_behaviour_tb
	import ddr_link_pkg::*;
;
	// Clock, reset and register port
	logic        core_clk;
	logic        rst_n;
	logic [2:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_rdata;
	logic        irq;
	// Device mode inputs and status
	logic        rtt_enable;
	logic        parity_enable;
	logic        crc_enable;
	logic [2:0]  mode_reg_five;
	logic        mode_reg_four_a4;
	logic        temp_critical;
	logic        termination_active;
	logic        vref_monitor_active;
	// Bench bookkeeping
	int          err_count;
	int          n_checks;
	int          i;
	logic [31:0] d;
	logic [31:0] w;
	logic [31:0] w2;
	logic [3:0]  m;
	logic [3:0]  bm;
	logic [1:0]  a;

	// Both ends joined by the link
	ddr_link_if link ();
	ddr_ctrl_end i_ddr_ctrl_end (.core_clk(core_clk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .link(link));
	ddr_dram_end i_ddr_dram_end (.core_clk(core_clk), .link(link),
		.rtt_enable(rtt_enable), .parity_enable(parity_enable),
		.crc_enable(crc_enable), .mode_reg_five(mode_reg_five),
		.mode_reg_one_a11(1'b0), .mode_reg_four_a4(mode_reg_four_a4),
		.conn_test(1'b0), .temp_critical(temp_critical),
		.termination_active(termination_active),
		.vref_monitor_active(vref_monitor_active));
	ddr_link_checker i_ddr_link_checker (.core_clk(core_clk), .rst_n(rst_n),
		.reset_link_n(link.reset_link_n), .cs_n(link.cs_n),
		.activate_strobe_n(link.activate_strobe_n),
		.row_strobe_or_addr16(link.row_strobe_or_addr16),
		.col_strobe_or_addr15(link.col_strobe_or_addr15),
		.write_strobe_or_addr14(link.write_strobe_or_addr14),
		.bg(link.bg), .ba(link.ba), .addr(link.addr), .parity(link.parity),
		.termination_enable_in(link.termination_enable_in),
		.h_dq_oe_n(link.h_dq_oe_n), .d_dq_oe_n(link.d_dq_oe_n),
		.d_strobe_oe_n(link.d_strobe_oe_n), .d_mask_oe_n(link.d_mask_oe_n),
		.lower_byte_strobe(link.lower_byte_strobe), .alert_n(link.alert_n),
		.event_n(link.event_n), .rtt_enable(rtt_enable),
		.parity_enable(parity_enable), .temp_critical(temp_critical),
		.termination_active(termination_active));

	// Free-running core clock
	always #20 core_clk = ~core_clk;

	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got,
				exp);
		end
	endtask : chk

	// Verdict and end of run
	task automatic tally_and_finish;
		if (err_count == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : tally_and_finish

	// One-cycle register write
	task automatic wr(input logic [2:0] ad, input logic [31:0] v);
		reg_addr <= ad;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		@(posedge core_clk);
	endtask : wr

	// One-cycle register read, data taken in the following cycle
	task automatic rd(input logic [2:0] ad, output logic [31:0] v);
		reg_addr <= ad;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(posedge core_clk);
		v = reg_rdata;
	endtask : rd

	// Poll until the link is idle, bounded
	task automatic wait_idle;
		logic [31:0] s;
		int n;
		rd(REG_STATUS, s);
		for (n = 0; n < 60 && s[ST_BUSY] !== 1'b0; n++)
			rd(REG_STATUS, s);
		chk(32'(s[ST_BUSY]), 32'h0);
	endtask : wait_idle

	// Issue one link command and wait for it
	task automatic xfer(input logic [1:0] op, input logic [1:0] ad,
		input logic [31:0] v);
		if (op == OP_WRITE)
			wr(REG_WDATA, v);
		wr(REG_CMD, {24'h0, ad, 4'h0, op});
		wait_idle();
	endtask : xfer

	// Expected memory word after a masked write
	function automatic logic [31:0] merge(input logic [31:0] o,
		input logic [31:0] n, input logic [3:0] k);
		for (int b = 0; b < 4; b++)
			if (k[b])
				n[8*b+:8] = o[8*b+:8];
		return n;
	endfunction : merge

	// Watchdog
	initial
	begin
		#(CLK_PERIOD_NS * 20000);
		err_count++;
		tally_and_finish();
	end

	// Main sequence
	initial
	begin
		core_clk = 1'b0;
		rst_n = 1'b0;
		reg_addr = 3'h0;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		rtt_enable = 1'b0;
		parity_enable = 1'b1;
		crc_enable = 1'b0;
		mode_reg_five = 3'h0;
		mode_reg_four_a4 = 1'b0;
		temp_critical = 1'b0;
		err_count = 0;
		n_checks = 0;
		void'($urandom(33804));
		repeat (3) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		rd(3'h6, d);
		chk(d, 32'h0);
		rd(REG_CTRL, d);
		chk(d, 32'(CTRL_RESET));
		wr(REG_MASK, 32'hF);
		xfer(OP_ACT, 2'h0, 32'h0);
		// Random bursts over checksum, inversion and mask modes
		for (i = 0; i < 12; i++)
		begin
			m = 4'($urandom);
			m[1] = m[1] & ~m[2];
			bm = 4'($urandom);
			a = 2'($urandom);
			w = (i < 2) ? {32{i[0]}} : $urandom;
			w2 = (i < 2) ? ~w : $urandom;
			crc_enable <= m[0];
			mode_reg_five <= {m[1], m[1], m[2]};
			wr(REG_CTRL, {28'h0, m[1], m[2], m[1], m[0]});
			xfer(OP_WRITE, a, w);
			wr(REG_CTRL, {20'h0, bm, 4'h0, m[1], m[2], m[1], m[0]});
			xfer(OP_WRITE, a, w2);
			xfer(OP_READ, a, 32'h0);
			rd(REG_RDATA, d);
			chk(d, merge(w, w2, bm & {4{m[2]}}));
			rd(REG_STATUS, d);
			chk(32'(d[3:0]), 32'h1);
			wr(REG_STATUS, 32'hF);
			@(posedge core_clk);
			chk(32'(irq), 32'h0);
		end
		// Termination and reference monitor follow their settings
		for (i = 0; i < 4; i++)
		begin
			rtt_enable <= i[0];
			mode_reg_four_a4 <= i[1];
			wr(REG_CTRL, 32'(i[1]) << CTL_TERM);
			repeat (3) @(posedge core_clk);
			chk(32'(termination_active), 32'(i[0] & i[1]));
			chk(32'(vref_monitor_active), 32'(i[1]));
		end
		// Temperature event raises status and interrupt
		temp_critical <= 1'b1;
		repeat (4) @(posedge core_clk);
		temp_critical <= 1'b0;
		rd(REG_STATUS, d);
		chk(32'(d[ST_EVENT]), 32'h1);
		chk(32'(irq), 32'h1);
		wr(REG_STATUS, 32'hF);
		// Parity fault on a read, then the same fault with checking off
		wr(REG_CTRL, 32'h20);
		wr(REG_CMD, 32'h0);
		wait_idle();
		repeat (12) @(posedge core_clk);
		rd(REG_STATUS, d);
		chk(32'(d[ST_ALERT]), 32'h1);
		wr(REG_STATUS, 32'hF);
		parity_enable <= 1'b0;
		xfer(OP_READ, 2'h0, 32'h0);
		rd(REG_STATUS, d);
		chk(32'(d[ST_ALERT]), 32'h0);
		// Link reset held and released
		wr(REG_CTRL, 32'h40);
		repeat (2) @(posedge core_clk);
		wr(REG_CTRL, 32'h0);
		tally_and_finish();
	end
endmodule : ddr4_module_pin_interface_behaviour_tb
